/* verilog/iolcr_defs.svh */
/*
  Constants of the link width and link control register bank.
  Assumes a 64-bit register port with byte enables and a 20 MHz core clock.
*/
// Operation
// - Identification register returns fixed maker code low, unit code next half, read-only.
// - Class register is read-only and reports the other-bridge class code.
// - Line size field always reads the constant for a 128-byte cache line.
// - Class register carries a read-only 8-bit revision that tracks silicon changes.
// - Width writes take effect only when that link is soft-reset.
// - Double-wide bits for links 0 and 2 are ignored while low quad bit set.
// - Double-wide bits for links 4 and 6 are ignored while high quad bit set.
// - Two quad-wide bits make link 0 and link 4 quad width.
// - Spare width register bits store and return writes but steer nothing.
// - After reset every link runs single width.
// - Eight per-link control registers, index 0 to 7.
// - Writing 1 to reset trigger soft-resets that link and its guest.
// - Reset-done flag reads 1 while link resets, then returns to 0 alone.
// - Hard-fail bit chooses hard-fail or all-ones completion for failing reads.
// - Arm bit enables log clearing; any log change drops it.
// - Clear request clears log only while armed; failed attempt drops it.
// - Request with arm written 0 and armed ends 1 on success, else both 0.
// - Error stays in effect for the link until the log is really cleared.
// - Every register honours the byte enables of an 8-byte write.
`ifndef IOLCR_DEFS_SVH
`define IOLCR_DEFS_SVH

`define IOLCR_NLINK         8
`define IOLCR_ID_ADDR       32'hFED0_1000
`define IOLCR_FC_ADDR       32'hFED0_1008
`define IOLCR_CFG_ADDR      32'hFED0_1010
`define IOLCR_CTL_BASE      32'hFED0_1040

`define IOLCR_MAKER_CODE    16'hA5C3
`define IOLCR_UNIT_CODE     16'h3C5A
`define IOLCR_REVISION      8'h01
`define IOLCR_CLASS_CODE    24'h068000
`define IOLCR_LINE_SIZE     8'h20

`define IOLCR_CFG_RST       16'h00FF
`define IOLCR_CFG_D0        8
`define IOLCR_CFG_D2        9
`define IOLCR_CFG_D4        10
`define IOLCR_CFG_D6        11
`define IOLCR_CFG_Q0        12
`define IOLCR_CFG_Q4        13

`define IOLCR_CTL_RF        0
`define IOLCR_CTL_CL        5
`define IOLCR_CTL_CE        6
`define IOLCR_CTL_HF        7
`define IOLCR_CTL_RC        32

`define IOLCR_CLK_NS        50
`define IOLCR_RST_HOLD_NS   800
`define IOLCR_RST_HOLD_CYC  ((`IOLCR_RST_HOLD_NS + `IOLCR_CLK_NS - 1) / `IOLCR_CLK_NS)
`define IOLCR_CNT_W         5

`endif

/* verilog/iolcr_pkg.sv */
/*
  Types shared by the link register bank modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iolcr_pkg;
  typedef enum logic [1:0] {
    IOLCR_W_SINGLE = 2'h0,
    IOLCR_W_DOUBLE = 2'h1,
    IOLCR_W_QUAD   = 2'h2
  } iolcr_width_e;

  typedef enum logic {
    IOLCR_ST_IDLE = 1'h0,
    IOLCR_ST_BUSY = 1'h1
  } iolcr_rst_st_e;
endpackage

/* verilog/iolcr_link_if.sv */
/*
  Carrier between the register bank and one link control slice.
  Assumes both ends sit on the same core clock.
*/
interface iolcr_link_if;
  logic       wr;
  logic [7:0] wbyte;
  logic       log_change;
  logic       busy;
  logic       hf;
  logic       ce;
  logic       cl;
  logic       start;
  logic       log_clear;
  logic       err_active;

  modport hub  (output wr, wbyte, log_change,
                input  busy, hf, ce, cl, start, log_clear, err_active);
  modport port (input  wr, wbyte, log_change,
                output busy, hf, ce, cl, start, log_clear, err_active);
endinterface

/* verilog/iolcr_link_ctl.sv */
/*
  One link control slice: soft reset sequencing, hard-fail choice, error log clearing.
  Assumes the hub decodes writes and the log change pulse is on the core clock.
*/
`include "iolcr_defs.svh"

module iolcr_link_ctl (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   nrst_i,
  // Hub side
  iolcr_link_if.port  lk
);
  iolcr_pkg::iolcr_rst_st_e      st_r, st_nxt;
  logic [`IOLCR_CNT_W-1:0]       cnt_r, cnt_nxt;
  logic                          hf_r, hf_nxt;
  logic                          ce_r, ce_nxt;
  logic                          cl_r, cl_nxt;
  logic                          clr_r, clr_nxt;
  logic                          err_r, err_nxt;
  logic                          start;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    hf_nxt  = hf_r;
    ce_nxt  = ce_r;
    cl_nxt  = cl_r;
    clr_nxt = 1'b0;
    err_nxt = err_r;
    start   = 1'b0;
    case (st_r)
      iolcr_pkg::IOLCR_ST_IDLE: begin
        // A trigger during a running reset is dropped
        if (lk.wr && lk.wbyte[`IOLCR_CTL_RF]) begin
          st_nxt  = iolcr_pkg::IOLCR_ST_BUSY;
          cnt_nxt = `IOLCR_CNT_W'(`IOLCR_RST_HOLD_CYC - 1);
          start   = 1'b1;
        end
      end
      iolcr_pkg::IOLCR_ST_BUSY: begin
        if (cnt_r == '0) begin
          st_nxt = iolcr_pkg::IOLCR_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - `IOLCR_CNT_W'(1);
        end
      end
      default: begin
        st_nxt = iolcr_pkg::IOLCR_ST_IDLE;
      end
    endcase
    if (lk.wr) begin
      hf_nxt = lk.wbyte[`IOLCR_CTL_HF];
      case ({lk.wbyte[`IOLCR_CTL_CL], lk.wbyte[`IOLCR_CTL_CE]})
        2'b10: begin
          // Clear only while armed and the log is steady this cycle
          if (ce_r && !lk.log_change) begin
            cl_nxt  = 1'b1;
            clr_nxt = 1'b1;
          end else begin
            cl_nxt = 1'b0;
          end
          ce_nxt = 1'b0;
        end
        default: begin
          // Both bits set is treated as a plain arm write
          cl_nxt = 1'b0;
          ce_nxt = lk.wbyte[`IOLCR_CTL_CE] && !lk.log_change;
        end
      endcase
    end else if (lk.log_change) begin
      ce_nxt = 1'b0;
    end
    if (lk.log_change) begin
      err_nxt = 1'b1;
    end else if (clr_nxt) begin
      err_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r  <= iolcr_pkg::IOLCR_ST_IDLE;
      cnt_r <= '0;
      hf_r  <= 1'b0;
      ce_r  <= 1'b0;
      cl_r  <= 1'b0;
      clr_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      hf_r  <= hf_nxt;
      ce_r  <= ce_nxt;
      cl_r  <= cl_nxt;
      clr_r <= clr_nxt;
      err_r <= err_nxt;
    end
  end

  assign lk.busy       = (st_r == iolcr_pkg::IOLCR_ST_BUSY);
  assign lk.start      = start;
  assign lk.hf         = hf_r;
  assign lk.ce         = ce_r;
  assign lk.cl         = cl_r;
  assign lk.log_clear  = clr_r;
  assign lk.err_active = err_r;

  rst_len_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lk.start |=> lk.busy ##15 lk.busy ##1 !lk.busy)
    else $error("link reset length wrong");
  clear_ok_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lk.wr && lk.wbyte[`IOLCR_CTL_CL] && !lk.wbyte[`IOLCR_CTL_CE] && ce_r && !lk.log_change)
    |=> lk.cl && !lk.ce && lk.log_clear && !lk.err_active)
    else $error("armed clear did not succeed");
  clear_fail_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lk.wr && lk.wbyte[`IOLCR_CTL_CL] && !lk.wbyte[`IOLCR_CTL_CE] && (!ce_r || lk.log_change))
    |=> !lk.cl && !lk.ce && !lk.log_clear)
    else $error("unarmed clear took effect");
  arm_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lk.log_change |=> !lk.ce)
    else $error("arm survived a log change");
  err_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lk.err_active && !clr_nxt) |=> lk.err_active)
    else $error("error dropped without log clear");

  reset_seen_c: cover property (@(posedge clk_i) disable iff (!nrst_i) lk.start ##17 !lk.busy);
  clear_seen_c: cover property (@(posedge clk_i) disable iff (!nrst_i) lk.log_clear);
  race_seen_c:  cover property (@(posedge clk_i) disable iff (!nrst_i)
    lk.ce && lk.wr && lk.wbyte[`IOLCR_CTL_CL] && lk.log_change);
endmodule // iolcr_link_ctl

/* verilog/iolcr_regs.sv */
/*
  Register bank of the link width setup and the eight link control registers.
  Assumes a 64-bit register port on the core clock; all inputs come from same-clock logic.
*/
`include "iolcr_defs.svh"

module iolcr_regs #(
  // Identity values, arbitrary
  parameter logic [15:0] MAKER_CODE = `IOLCR_MAKER_CODE,
  parameter logic [15:0] UNIT_CODE  = `IOLCR_UNIT_CODE,
  parameter logic [7:0]  REVISION   = `IOLCR_REVISION
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic        reg_req_i,
  input  wire logic        reg_we_i,
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [7:0]  reg_be_i,
  input  wire logic [63:0] reg_wdata_i,
  output      logic        reg_ack_o,
  output      logic [63:0] reg_rdata_o,
  // Link controllers
  input  wire logic [7:0]  link_log_change_i,
  output      logic [7:0]  link_soft_reset_o,
  output      logic [15:0] link_width_o,
  output      logic [7:0]  link_fail_hard_o,
  output      logic [7:0]  link_log_clear_o,
  output      logic [7:0]  link_err_active_o
);
  iolcr_pkg::iolcr_width_e width_r [`IOLCR_NLINK];
  iolcr_pkg::iolcr_width_e width_nxt [`IOLCR_NLINK];
  logic [15:0]             cfg_r, cfg_nxt;
  logic [63:0]             rdata_r, rdata_nxt;
  logic                    ack_r, ack_nxt;
  logic                    hit_id, hit_fc, hit_cfg, hit_ctl;
  logic [2:0]              idx;
  logic [7:0]              busy, hf, ce, cl, start;

  iolcr_link_if lk [`IOLCR_NLINK] ();

  // Only the quad bit of a group hides the double bits of that group
  function automatic iolcr_pkg::iolcr_width_e width_of(input logic [2:0] n, input logic [15:0] c);
    iolcr_pkg::iolcr_width_e w;
    w = iolcr_pkg::IOLCR_W_SINGLE;
    case (n)
      3'h0: begin
        if (c[`IOLCR_CFG_Q0]) begin
          w = iolcr_pkg::IOLCR_W_QUAD;
        end else if (c[`IOLCR_CFG_D0]) begin
          w = iolcr_pkg::IOLCR_W_DOUBLE;
        end
      end
      3'h2: begin
        if (!c[`IOLCR_CFG_Q0] && c[`IOLCR_CFG_D2]) begin
          w = iolcr_pkg::IOLCR_W_DOUBLE;
        end
      end
      3'h4: begin
        if (c[`IOLCR_CFG_Q4]) begin
          w = iolcr_pkg::IOLCR_W_QUAD;
        end else if (c[`IOLCR_CFG_D4]) begin
          w = iolcr_pkg::IOLCR_W_DOUBLE;
        end
      end
      3'h6: begin
        if (!c[`IOLCR_CFG_Q4] && c[`IOLCR_CFG_D6]) begin
          w = iolcr_pkg::IOLCR_W_DOUBLE;
        end
      end
      default: begin
        w = iolcr_pkg::IOLCR_W_SINGLE;
      end
    endcase
    return w;
  endfunction

  assign hit_id  = ({reg_addr_i[31:3], 3'h0} == `IOLCR_ID_ADDR);
  assign hit_fc  = ({reg_addr_i[31:3], 3'h0} == `IOLCR_FC_ADDR);
  assign hit_cfg = ({reg_addr_i[31:3], 3'h0} == `IOLCR_CFG_ADDR);
  assign hit_ctl = ({reg_addr_i[31:6], 6'h00} == `IOLCR_CTL_BASE);
  assign idx     = reg_addr_i[5:3];

  genvar g;
  generate
    for (g = 0; g < `IOLCR_NLINK; g++) begin : g_link
      // Every writable control bit lives in byte 0, so only that lane writes
      assign lk[g].wr         = reg_req_i && reg_we_i && hit_ctl && (idx == 3'(g)) && reg_be_i[0];
      assign lk[g].wbyte      = reg_wdata_i[7:0];
      assign lk[g].log_change = link_log_change_i[g];
      assign busy[g]          = lk[g].busy;
      assign hf[g]            = lk[g].hf;
      assign ce[g]            = lk[g].ce;
      assign cl[g]            = lk[g].cl;
      assign start[g]         = lk[g].start;
      assign link_soft_reset_o[g]     = lk[g].busy;
      assign link_fail_hard_o[g]      = lk[g].hf;
      assign link_log_clear_o[g]      = lk[g].log_clear;
      assign link_err_active_o[g]     = lk[g].err_active;
      assign link_width_o[2*g +: 2]   = width_r[g];
      iolcr_link_ctl u_ctl (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .lk     (lk[g])
      );
    end
  endgenerate

  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = '0;
    ack_nxt   = reg_req_i;
    for (int b = 0; b < 2; b++) begin
      if (reg_req_i && reg_we_i && hit_cfg && reg_be_i[b]) begin
        cfg_nxt[b*8 +: 8] = reg_wdata_i[b*8 +: 8];
      end
    end
    for (int n = 0; n < `IOLCR_NLINK; n++) begin
      // Stored setup reaches a link only at its reset start
      width_nxt[n] = start[n] ? width_of(3'(n), cfg_r) : width_r[n];
    end
    if (reg_req_i && !reg_we_i) begin
      if (hit_id) begin
        rdata_nxt[31:0] = {UNIT_CODE, MAKER_CODE};
      end else if (hit_fc) begin
        rdata_nxt[7:0]   = REVISION;
        rdata_nxt[31:8]  = `IOLCR_CLASS_CODE;
        rdata_nxt[39:32] = `IOLCR_LINE_SIZE;
      end else if (hit_cfg) begin
        rdata_nxt[15:0] = cfg_r;
      end else if (hit_ctl) begin
        rdata_nxt[`IOLCR_CTL_RC] = busy[idx];
        rdata_nxt[`IOLCR_CTL_HF] = hf[idx];
        rdata_nxt[`IOLCR_CTL_CE] = ce[idx];
        rdata_nxt[`IOLCR_CTL_CL] = cl[idx];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r   <= `IOLCR_CFG_RST;
      rdata_r <= '0;
      ack_r   <= 1'b0;
      for (int n = 0; n < `IOLCR_NLINK; n++) begin
        width_r[n] <= iolcr_pkg::IOLCR_W_SINGLE;
      end
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
      for (int n = 0; n < `IOLCR_NLINK; n++) begin
        width_r[n] <= width_nxt[n];
      end
    end
  end

  assign reg_ack_o   = ack_r;
  assign reg_rdata_o = rdata_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  id_read_a: assert property (
    (reg_req_i && !reg_we_i && hit_id) |=> reg_ack_o && reg_rdata_o[31:0] == {UNIT_CODE, MAKER_CODE})
    else $error("identification read wrong");
  class_read_a: assert property (
    (reg_req_i && !reg_we_i && hit_fc) |=> reg_rdata_o[31:8] == 24'h068000)
    else $error("class code read wrong");
  line_size_a: assert property (
    (reg_req_i && !reg_we_i && hit_fc) |=> reg_rdata_o[63:32] == 32'h0000_0020)
    else $error("line size read wrong");
  revision_rd_a: assert property (
    (reg_req_i && !reg_we_i && hit_fc) |=> reg_rdata_o[7:0] == REVISION)
    else $error("revision read wrong");
  width_hold_a: assert property (
    (start == 8'h00) |=> $stable(link_width_o))
    else $error("width changed without reset");
  low_quad_a: assert property (
    (start[2] && cfg_r[12]) |=> link_width_o[5:4] == 2'h0)
    else $error("link two double despite quad");
  high_quad_a: assert property (
    (start[6] && cfg_r[13]) |=> link_width_o[13:12] == 2'h0)
    else $error("link six double despite quad");
  quad_set_a: assert property (
    (start[0] && cfg_r[12]) |=> link_width_o[1:0] == 2'h2)
    else $error("link zero not quad");
  spare_rw_a: assert property (
    (reg_req_i && reg_we_i && hit_cfg && reg_be_i[0]) |=> cfg_r[7:0] == $past(reg_wdata_i[7:0]))
    else $error("spare bits not stored");
  width_rst_a: assert property (
    !$past(nrst_i) |-> link_width_o == 16'h0000)
    else $error("width not single after reset");
  lane_mask_a: assert property (
    (reg_req_i && reg_we_i && hit_cfg && !reg_be_i[1]) |=> $stable(cfg_r[15:8]))
    else $error("disabled byte lane written");
  rc_read_a: assert property (
    (reg_req_i && !reg_we_i && hit_ctl) |=> reg_rdata_o[32] == $past(busy[idx]))
    else $error("reset done flag misread");

  quad_cfg_c: cover property (start[4] && cfg_r[13]);
  ctl_read_c: cover property (reg_req_i && !reg_we_i && hit_ctl && busy[idx]);
endmodule // iolcr_regs

/* sim/iolcr_link_model.sv */
/*
  Far side model of the eight link controllers: raises error log changes, counts log clears.
  Assumes the same core clock as the register bank; the bench calls log_error.
*/
module iolcr_link_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Register bank side
  input  wire logic [7:0] link_soft_reset_i,
  input  wire logic [7:0] link_log_clear_i,
  output      logic [7:0] link_log_change_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int         clear_cnt [8];
  logic [7:0] bus_held;
  logic [7:0] rst_prev;

  initial link_log_change_o = 8'h00;

  // Guest bus stays held from each soft reset until software releases it
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_prev <= 8'h00;
      bus_held <= 8'h00;
    end else begin
      rst_prev <= link_soft_reset_i;
      for (int k = 0; k < 8; k++) begin
        if (link_soft_reset_i[k] === 1'b1 && rst_prev[k] === 1'b0) bus_held[k] <= 1'b1;
      end
    end
  end

  // Software writes the guest's bus reset bit to zero
  task automatic release_bus(input int n);
    @(posedge clk_i);
    bus_held[n] <= 1'b0;
  endtask

  // One-cycle pulse: a new error lands in the log of link n
  task automatic log_error(input int n);
    @(posedge clk_i);
    link_log_change_o <= 8'h01 << n;
    @(posedge clk_i);
    link_log_change_o <= 8'h00;
  endtask

  // Log drops only on a clear pulse; a soft reset alone keeps it
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      foreach (clear_cnt[k]) clear_cnt[k] = 0;
    end else begin
      foreach (clear_cnt[k]) if (link_log_clear_i[k] === 1'b1) clear_cnt[k] = clear_cnt[k] + 1;
    end
  end
endmodule // iolcr_link_model

/* sim/iolcr_regs_bench.sv */
/*
  Self-checking bench of the link width and link control register bank.
  Assumes iolcr_defs.svh on the include path and the far side model beside it.
*/
`include "iolcr_defs.svh"
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin err_count++; $display("wrong value at %0t ns: %s", $time, msg); end end

module iolcr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, nrst, req, we, ack;
  logic [31:0] addr;
  logic [7:0]  be, chg, sres, hf, lclr, eact;
  logic [63:0] wdata, rdata, rd;
  logic [15:0] width, cfg, exp_w;
  int          err_count, cmp_count, cyc, n;

  // Minimum guest bus reset time of 1 ms in core cycles
  localparam int BUS_RST_CYC = 1000000 / `IOLCR_CLK_NS;

  iolcr_regs iolcr_regs_i (.clk_i(clk), .nrst_i(nrst), .reg_req_i(req), .reg_we_i(we), .reg_addr_i(addr),
    .reg_be_i(be), .reg_wdata_i(wdata), .reg_ack_o(ack), .reg_rdata_o(rdata), .link_log_change_i(chg),
    .link_soft_reset_o(sres), .link_width_o(width), .link_fail_hard_o(hf), .link_log_clear_o(lclr),
    .link_err_active_o(eact));

  iolcr_link_model iolcr_link_model_i (.clk_i(clk), .nrst_i(nrst), .link_soft_reset_i(sres),
    .link_log_clear_i(lclr), .link_log_change_o(chg));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("counts: %0d compared, %0d wrong", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Generous ceiling; the 1 ms bus wait dominates the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("wrong value at %0t ns: run did not finish", $time);
      conclude();
    end
  end

  // One access: request for one edge, answer sampled just after the taking edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] b, input logic [63:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    `CHK(ack, 1'b1, "no answer")
    rd = rdata;
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [63:0] e, input string m);
    acc(1'b0, a, 8'h00, 64'h0);
    `CHK(rd, e, m)
  endtask

  function automatic logic [31:0] ctla(input int k);
    return `IOLCR_CTL_BASE + 32'(k * 8);
  endfunction

  // Absorbed links under a quad link stay marked single
  function automatic logic [1:0] wfun(input logic [15:0] c, input int k);
    case (k)
      0: return c[12] ? 2'h2 : {1'b0, c[8]};
      2: return c[12] ? 2'h0 : {1'b0, c[9]};
      4: return c[13] ? 2'h2 : {1'b0, c[10]};
      6: return c[13] ? 2'h0 : {1'b0, c[11]};
      default: return 2'h0;
    endcase
  endfunction

  // Soft reset of link k: width applied, flag read mid-reset, exact length
  task automatic sreset(input int k);
    acc(1'b1, ctla(k), 8'h01, 64'h1);
    exp_w[2*k +: 2] = wfun(cfg, k);
    `CHK(sres[k], 1'b1, "link not in soft reset")
    `CHK(width, exp_w, "width after soft reset")
    chk_rd(ctla(k), 64'h1_0000_0000, "reset done flag low");
    n = 0;
    while (sres[k] === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
      #1;
    end
    // Two busy edges already spent on the request and answer edges of the flag read
    `CHK(n, `IOLCR_RST_HOLD_CYC - 2, "soft reset length")
    chk_rd(ctla(k), 64'h0, "reset done flag stuck");
  endtask

  initial begin
    nrst = 1'b0;
    req = 1'b0;
    we = 1'b0;
    addr = 32'h0;
    be = 8'h00;
    wdata = 64'h0;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    cfg = 16'h00FF;
    exp_w = 16'h0000;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    `CHK(width, 16'h0000, "width not single after reset")
    chk_rd(`IOLCR_ID_ADDR, {32'h0, `IOLCR_UNIT_CODE, `IOLCR_MAKER_CODE}, "identity");
    acc(1'b1, `IOLCR_ID_ADDR, 8'hFF, 64'hFFFF_FFFF_FFFF_FFFF);
    chk_rd(`IOLCR_ID_ADDR, {32'h0, `IOLCR_UNIT_CODE, `IOLCR_MAKER_CODE}, "identity written");
    chk_rd(`IOLCR_FC_ADDR, {24'h0, 8'h20, 24'h068000, `IOLCR_REVISION}, "class");
    acc(1'b1, `IOLCR_FC_ADDR, 8'hFF, 64'h0);
    chk_rd(`IOLCR_FC_ADDR, {24'h0, 8'h20, 24'h068000, `IOLCR_REVISION}, "class written");
    chk_rd(`IOLCR_CFG_ADDR, 64'h00FF, "setup reset value");
    for (int k = 0; k < 8; k++) chk_rd(ctla(k), 64'h0, "control reset value");
    chk_rd(32'hFED0_1100, 64'h0, "unmapped read");
    $display("test reset values done");

    acc(1'b1, `IOLCR_CFG_ADDR, 8'h02, 64'hFFFF_FFFF_FFFF_0F5A);
    chk_rd(`IOLCR_CFG_ADDR, 64'h0FFF, "upper lane only");
    acc(1'b1, `IOLCR_CFG_ADDR, 8'h01, 64'hFFFF_FFFF_FFFF_FF5A);
    cfg = 16'h0F5A;
    chk_rd(`IOLCR_CFG_ADDR, {48'h0, cfg}, "spare bits");
    `CHK(width, 16'h0000, "width moved before soft reset")
    for (int k = 0; k < 8; k += 2) sreset(k);
    `CHK(width, 16'h1111, "double widths")
    acc(1'b1, `IOLCR_CFG_ADDR, 8'h03, 64'h3F5A);
    cfg = 16'h3F5A;
    for (int k = 0; k < 8; k++) sreset(k);
    `CHK(width, 16'h0202, "quad widths")
    `CHK(iolcr_link_model_i.bus_held, 8'hFF, "guest bus not held by soft reset")
    repeat (BUS_RST_CYC) @(posedge clk);
    for (int k = 0; k < 8; k++) iolcr_link_model_i.release_bus(k);
    #1;
    `CHK(iolcr_link_model_i.bus_held, 8'h00, "guest bus still held")
    $display("test link width done");

    acc(1'b1, ctla(3), 8'hFE, 64'h1);
    `CHK(sres, 8'h00, "reset with lane off")
    acc(1'b1, ctla(5), 8'h01, 64'h80);
    `CHK(hf, 8'h20, "hard fail out")
    acc(1'b1, ctla(5), 8'hFE, 64'h0);
    chk_rd(ctla(5), 64'h80, "hard fail kept");
    acc(1'b1, ctla(5), 8'h01, 64'h0);
    `CHK(hf, 8'h00, "hard fail off")
    $display("test control bits done");

    iolcr_link_model_i.log_error(1);
    @(posedge clk);
    #1;
    `CHK(eact[1], 1'b1, "error not in effect")
    acc(1'b1, ctla(1), 8'h01, 64'h40);
    chk_rd(ctla(1), 64'h40, "arm");
    acc(1'b1, ctla(1), 8'h01, 64'h20);
    chk_rd(ctla(1), 64'h20, "request after clear");
    `CHK(iolcr_link_model_i.clear_cnt[1], 1, "log not cleared")
    `CHK(eact[1], 1'b0, "error still in effect")
    iolcr_link_model_i.log_error(1);
    acc(1'b1, ctla(1), 8'h01, 64'h40);
    iolcr_link_model_i.log_error(1);
    chk_rd(ctla(1), 64'h0, "arm survived log change");
    acc(1'b1, ctla(1), 8'h01, 64'h20);
    chk_rd(ctla(1), 64'h0, "failed request kept");
    `CHK(iolcr_link_model_i.clear_cnt[1], 1, "log cleared unarmed")
    `CHK(eact[1], 1'b1, "error dropped early")
    acc(1'b1, ctla(1), 8'h01, 64'h40);
    // New error lands on the very edge that takes the armed request
    fork
      iolcr_link_model_i.log_error(1);
      acc(1'b1, ctla(1), 8'h01, 64'h20);
    join
    chk_rd(ctla(1), 64'h0, "clear raced a new error");
    `CHK(iolcr_link_model_i.clear_cnt[1], 1, "log cleared over new error")
    `CHK(eact[1], 1'b1, "error dropped by raced clear")
    $display("test error clear done");
    conclude();
  end
endmodule // iolcr_regs_bench
